// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic [1:0]  spi_done;
  logic [1:0]  spi_abort;
  logic [3:0]  tm_a;
  logic [3:0]  tm_p;
  logic [2:0]  tw_evt;
  logic        lvd;
  logic        eep;
  logic [1:0]  cmp;
  logic        adc;
  logic        stack_full;
  logic        ack;
  logic        irq_req;
  logic [2:0]  irq_vec;
  logic        wake;
  logic        wake_seen;
  logic [1:0]  sub_div;
  int          irq_cyc;
  int          n_mismatch;
  int          compares;

  // The single slave's ready is fed back as the bus ready.
  tbgi_irq_ctrl i_tbgi_irq_ctrl (.CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HREADY_I(hready), .HWDATA_I(hwdata),
    .HREADYOUT_O(hready), .HRDATA_O(hrdata), .HRESP_O(hresp), .SUB_CLK_I(sub_div[1]),
    .SPI_BYTE_DONE_I(spi_done), .SPI_ABORT_I(spi_abort), .TM_MATCH_A_I(tm_a),
    .TM_MATCH_P_I(tm_p), .TWOWIRE_EVT_I(tw_evt), .LOW_VOLT_I(lvd), .EEPROM_WR_DONE_I(eep),
    .CMP_OUT_I(cmp), .ADC_DONE_I(adc), .STACK_FULL_I(stack_full), .IRQ_ACK_I(ack),
    .IRQ_REQ_O(irq_req), .IRQ_VEC_O(irq_vec), .WAKE_O(wake));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Four-state compare, so an unknown never passes.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Ready is read in the active region of the edge, so it is the sampled value.
  task wait_rdy;
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hready !== 1'b1 && k < 20);
    if (hready !== 1'b1)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0000_00, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task rd(input logic [7:0] a, output logic [31:0] r);
    ahb(1'b0, a, 32'h0000_0000, r);
  endtask

  // Waits for a request, noting any wake pulse seen on the way.
  task wait_irq(input int lim);
    irq_cyc = 0;
    wake_seen = 1'b0;
    do
    begin
      @(posedge clk);
      irq_cyc++;
      if (wake === 1'b1)
        wake_seen = 1'b1;
    end
    while (irq_req !== 1'b1 && irq_cyc < lim);
    if (irq_req !== 1'b1)
    begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, 1'b0, 1'b1);
      wrap_up();
    end
  endtask

  task ack_irq;
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
    chk({31'h0, irq_req}, 32'h0000_0000);
  endtask

  // Event k: timers 0..7, two-wire 8..10, low volt, eeprom, comparators, converter.
  task fire(input int k);
    if (k < 8 && k % 2 == 1)
      tm_p[k / 2] <= 1'b1;
    else if (k < 8)
      tm_a[k / 2] <= 1'b1;
    else if (k < 11)
      tw_evt[k - 8] <= 1'b1;
    else if (k == 11)
      lvd <= 1'b1;
    else if (k == 12)
      eep <= 1'b1;
    else if (k < 15)
      cmp[k - 13] <= ~cmp[k - 13];
    else
      adc <= 1'b1;
    @(posedge clk);
    tm_a <= 4'h0;
    tm_p <= 4'h0;
    tw_evt <= 3'h0;
    eep <= 1'b0;
    adc <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_regs;
    logic [31:0] r;
    rd(tbgi_pkg::ADDR_TIME_BASE1_CONTROL, r);
    chk(r, 32'h0000_0000);
    wr(tbgi_pkg::ADDR_TIME_BASE1_CONTROL, 32'hFFFF_FFFF);
    rd(tbgi_pkg::ADDR_TIME_BASE1_CONTROL, r);
    chk(r, 32'h0000_0087);
    wr(tbgi_pkg::ADDR_TIME_BASE1_CONTROL, 32'h0000_0000);
    wr(tbgi_pkg::ADDR_PSC, 32'h0000_0003);
    rd(tbgi_pkg::ADDR_PSC, r);
    chk(r, 32'h0000_0003);
    rd(8'h18, r);
    chk(r, 32'h0000_0000);
    chk({31'h0, hresp}, 32'h0000_0000);
    wr(tbgi_pkg::ADDR_PSC, 32'h0000_0000);
    $display("done regs");
  endtask

  task t_spi;
    logic [31:0] r;
    wr(tbgi_pkg::ADDR_CORE_EN, 32'h0000_0003);
    spi_done[0] <= 1'b1;
    @(posedge clk);
    spi_done <= 2'h0;
    wait_irq(20);
    chk({31'h0, wake_seen}, 32'h0000_0001);
    chk({29'h0, irq_vec}, 32'h0000_0000);
    ack_irq();
    rd(tbgi_pkg::ADDR_CORE_EN, r);
    chk(r, 32'h0000_0002);
    rd(tbgi_pkg::ADDR_CORE_FLG, r);
    chk(r, 32'h0000_0000);
    // A full stack must hold back an otherwise enabled request.
    stack_full <= 1'b1;
    wr(tbgi_pkg::ADDR_CORE_EN, 32'h0000_0005);
    spi_abort[1] <= 1'b1;
    @(posedge clk);
    spi_abort <= 2'h0;
    repeat (6) @(posedge clk);
    chk({31'h0, irq_req}, 32'h0000_0000);
    stack_full <= 1'b0;
    wait_irq(20);
    chk({29'h0, irq_vec}, 32'h0000_0001);
    ack_irq();
    spi_done[0] <= 1'b1;
    @(posedge clk);
    spi_done <= 2'h0;
    @(posedge clk);
    chk({31'h0, wake}, 32'h0000_0001);
    wr(tbgi_pkg::ADDR_CORE_FLG, 32'h0000_0000);
    $display("done spi");
  endtask

  task t_group;
    logic [31:0] r;
    int          s;
    int          g;
    for (int k = 0; k < 16; k++)
    begin
      s = (k < 8) ? k : ((k < 11) ? 8 : k - 2);
      g = (k < 4) ? 0 : ((k < 8) ? 1 : ((k < 13) ? 2 : 3));
      wr(tbgi_pkg::ADDR_SRC_EN, 32'h0000_0001 << s);
      wr(tbgi_pkg::ADDR_CORE_EN, 32'h0000_0001);
      fire(k);
      repeat (6) @(posedge clk);
      chk({31'h0, irq_req}, 32'h0000_0000);
      wr(tbgi_pkg::ADDR_CORE_EN, 32'h0000_00F1);
      wait_irq(20);
      chk({29'h0, irq_vec}, 32'(g + 2));
      ack_irq();
      rd(tbgi_pkg::ADDR_CORE_FLG, r);
      chk(r, 32'h0000_0000);
      rd(tbgi_pkg::ADDR_CORE_EN, r);
      chk(r, 32'h0000_00F0);
      rd(tbgi_pkg::ADDR_SRC_FLG, r);
      chk(r, 32'h0000_0001 << s);
      wr(tbgi_pkg::ADDR_SRC_FLG, 32'h0000_0000);
    end
    $display("done group");
  endtask

  // Two requests land together; the lower vector must win.
  task t_prio;
    wr(tbgi_pkg::ADDR_SRC_EN, 32'h0000_3FFF);
    wr(tbgi_pkg::ADDR_CORE_EN, 32'h0000_00F5);
    spi_done[1] <= 1'b1;
    adc <= 1'b1;
    @(posedge clk);
    spi_done <= 2'h0;
    adc <= 1'b0;
    wait_irq(20);
    chk({29'h0, irq_vec}, 32'h0000_0001);
    ack_irq();
    wr(tbgi_pkg::ADDR_CORE_EN, 32'h0000_00F5);
    wait_irq(20);
    chk({29'h0, irq_vec}, 32'h0000_0005);
    ack_irq();
    wr(tbgi_pkg::ADDR_SRC_FLG, 32'h0000_0000);
    wr(tbgi_pkg::ADDR_CORE_FLG, 32'h0000_0000);
    $display("done prio");
  endtask

  task t_tb;
    logic [31:0] r;
    int          e;
    // Passes: system clock, system clock over four, period select one, sub clock pin.
    for (int i = 0; i < 4; i++)
    begin
      e = 256 << ((i == 2 ? 1 : 0) + (i == 1 || i == 3 ? 2 : 0));
      wr(tbgi_pkg::ADDR_TIME_BASE1_CONTROL, 32'h0000_0000);
      wr(tbgi_pkg::ADDR_CORE_FLG, 32'h0000_0000);
      wr(tbgi_pkg::ADDR_PSC, (i == 1) ? 32'h0000_0001 : ((i == 3) ? 32'h0000_0002 : 32'h0000_0000));
      wr(tbgi_pkg::ADDR_CORE_EN, 32'h0000_0009);
      wr(tbgi_pkg::ADDR_TIME_BASE1_CONTROL, (i == 2) ? 32'h0000_0081 : 32'h0000_0080);
      wait_irq(1100);
      chk({31'h0, irq_cyc >= e - 4 && irq_cyc <= e + 8}, 32'h0000_0001);
      chk({29'h0, irq_vec}, 32'h0000_0006);
      ack_irq();
    end
    wr(tbgi_pkg::ADDR_TIME_BASE1_CONTROL, 32'h0000_0000);
    wr(tbgi_pkg::ADDR_CORE_FLG, 32'h0000_0000);
    repeat (300) @(posedge clk);
    rd(tbgi_pkg::ADDR_CORE_FLG, r);
    chk(r, 32'h0000_0000);
    $display("done timebase");
  endtask

  // ----------------------------------------------------------------------
  // Clock, reset and main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Sub clock pin: one rising edge every four system cycles, changed on the clock edge.
  always @(posedge clk)
    sub_div <= sub_div + 2'h1;

  initial
  begin
    {rst_b, hsel, haddr, htrans, hwrite, hwdata} = '0;
    {spi_done, spi_abort, tm_a, tm_p, tw_evt, lvd, eep, cmp, adc, stack_full, ack} = '0;
    sub_div = 2'h0;
    n_mismatch = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_spi();
    t_group();
    t_prio();
    t_tb();
    wrap_up();
  end
endmodule

// ===== src/tbgi_irq_ctrl.sv
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module tbgi_irq_ctrl
(
  input  wire logic                         CLK_I,
  input  wire logic                         RST_B_I,
  input  wire logic                         HSEL_I,
  input  wire logic [31:0]                  HADDR_I,
  input  wire logic [1:0]                   HTRANS_I,
  input  wire logic                         HWRITE_I,
  input  wire logic                         HREADY_I,
  input  wire logic [31:0]                  HWDATA_I,
  output logic                              HREADYOUT_O,
  output logic [31:0]                       HRDATA_O,
  output logic                              HRESP_O,
  input  wire logic                         SUB_CLK_I,
  input  wire logic [tbgi_pkg::NUM_SPI-1:0] SPI_BYTE_DONE_I,
  input  wire logic [tbgi_pkg::NUM_SPI-1:0] SPI_ABORT_I,
  input  wire logic [tbgi_pkg::NUM_TM-1:0]  TM_MATCH_A_I,
  input  wire logic [tbgi_pkg::NUM_TM-1:0]  TM_MATCH_P_I,
  input  wire logic [2:0]                   TWOWIRE_EVT_I,
  input  wire logic                         LOW_VOLT_I,
  input  wire logic                         EEPROM_WR_DONE_I,
  input  wire logic [tbgi_pkg::NUM_CMP-1:0] CMP_OUT_I,
  input  wire logic                         ADC_DONE_I,
  input  wire logic                         STACK_FULL_I,
  input  wire logic                         IRQ_ACK_I,
  output logic                              IRQ_REQ_O,
  output logic [2:0]                        IRQ_VEC_O,
  output logic                              WAKE_O
);

  // All assertions of this block share the one clock and are off while reset is held.
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  // -------------------------------------------------------------------------
  // Helper functions
  // -------------------------------------------------------------------------

  // Mask of the counter bits that must all be one at the last tick of a period.
  function automatic logic [tbgi_pkg::TB_CNT_W-1:0] tb_mask(input logic [2:0] sel);
    logic [31:0] w;
    w = (32'h0000_0001 << (tbgi_pkg::TB_BASE + int'(sel))) - 32'h0000_0001;
    return w[tbgi_pkg::TB_CNT_W-1:0];
  endfunction

  // All request flags in one vector, compared before and after each edge for wake-up.
  function automatic logic [tbgi_pkg::NUM_FLG-1:0] all_flags(input tbgi_pkg::tbgi_state_t s);
    return {s.spi_f, s.tb_f, s.grp_f, s.src_f};
  endfunction

  // Lowest pending vector wins.
  function automatic logic [2:0] prio(input logic [tbgi_pkg::NUM_VEC-1:0] p);
    logic [2:0] v;
    v = 3'h0;
    for (int i = tbgi_pkg::NUM_VEC - 1; i >= 0; i--)
    begin
      if (p[i])
      begin
        v = 3'(i);
      end
    end
    return v;
  endfunction

  // -------------------------------------------------------------------------
  // State and combinational helpers
  // -------------------------------------------------------------------------
  tbgi_pkg::tbgi_state_t                r;
  tbgi_pkg::tbgi_state_t                n;
  logic                                 sub_rise;
  logic                                 psc_tick;
  logic                                 tb_expire;
  logic [tbgi_pkg::TB_CNT_W-1:0]        tb_m;
  logic [tbgi_pkg::NUM_SRC-1:0]         src_set;
  logic [tbgi_pkg::NUM_GRP-1:0]         grp_set;
  logic [tbgi_pkg::NUM_GRP-1:0]         grp_ready;
  logic [tbgi_pkg::NUM_VEC-1:0]         pend;
  logic                                 ack;
  logic [31:0]                          rd;
  logic [tbgi_pkg::NUM_FLG-1:0]         flg_now;

  // Next-state logic for the whole block.
  always_comb
  begin
    n = r;

    // Pin-level inputs pass two flops; edges are taken only behind the second.
    n.sub_s  = {r.sub_s[1:0], SUB_CLK_I};
    n.lv_s   = {r.lv_s[1:0], LOW_VOLT_I};
    n.cmp_s1 = CMP_OUT_I;
    n.cmp_s2 = r.cmp_s1;
    n.cmp_s3 = r.cmp_s2;
    sub_rise = r.sub_s[1] & ~r.sub_s[2];

    // Prescaler tick selection; the divide-by-four runs free so a source change needs no reset.
    n.div_cnt = r.div_cnt + 2'h1;
    case (r.psc_src)
      tbgi_pkg::PSC_SYS:  psc_tick = 1'h1;
      tbgi_pkg::PSC_DIV4: psc_tick = (r.div_cnt == tbgi_pkg::DIV4_END);
      default:            psc_tick = sub_rise;
    endcase

    // Time base 1 counter; held at zero while off so each enable starts a full period.
    tb_m      = tb_mask(r.tb_sel);
    tb_expire = r.tb_on && psc_tick && ((r.tb_cnt & tb_m) == tb_m);
    if (!r.tb_on)
    begin
      n.tb_cnt = '0;
    end
    else if (psc_tick)
    begin
      n.tb_cnt = r.tb_cnt + 15'h0001;
    end

    // Source events for the grouped flags.
    src_set = '0;
    for (int i = 0; i < tbgi_pkg::NUM_TM; i++)
    begin
      src_set[2*i]   = TM_MATCH_A_I[i];
      src_set[2*i+1] = TM_MATCH_P_I[i];
    end
    src_set[tbgi_pkg::SRC_TWI] = |TWOWIRE_EVT_I;
    src_set[tbgi_pkg::SRC_LVD] = r.lv_s[1] & ~r.lv_s[2];
    src_set[tbgi_pkg::SRC_EEP] = EEPROM_WR_DONE_I;
    src_set[tbgi_pkg::SRC_CMP +: tbgi_pkg::NUM_CMP] = r.cmp_s2 ^ r.cmp_s3;
    src_set[tbgi_pkg::SRC_ADC] = ADC_DONE_I;

    // A group is set by any member event and may call only with an enabled member flag.
    for (int g = 0; g < tbgi_pkg::NUM_GRP; g++)
    begin
      grp_set[g]   = |(src_set & tbgi_pkg::GRP_MASK[g]);
      grp_ready[g] = |(r.src_f & r.src_en & tbgi_pkg::GRP_MASK[g]);
    end

    // Register read value, unmapped addresses read zero.
    rd = 32'h0000_0000;
    case (r.bus_addr)
      tbgi_pkg::ADDR_PSC:      rd[1:0] = r.psc_src;
      tbgi_pkg::ADDR_TIME_BASE1_CONTROL:
      begin
        rd[tbgi_pkg::TIME_BASE1_CONTROL_ON_BIT] = r.tb_on;
        rd[2:0]                   = r.tb_sel;
      end
      tbgi_pkg::ADDR_CORE_EN:  rd[7:0] = {r.grp_en, r.tb_en, r.spi_en, r.glb_en};
      tbgi_pkg::ADDR_CORE_FLG: rd[6:0] = {r.grp_f, r.tb_f, r.spi_f};
      tbgi_pkg::ADDR_SRC_EN:   rd[tbgi_pkg::NUM_SRC-1:0] = r.src_en;
      tbgi_pkg::ADDR_SRC_FLG:  rd[tbgi_pkg::NUM_SRC-1:0] = r.src_f;
      default:                 rd = 32'h0000_0000;
    endcase

    // Bus slave: one wait state per transfer, so read data always come from a flop.
    case (r.bus)
      tbgi_pkg::BUS_IDLE:
      begin
        if (HSEL_I && HTRANS_I[1] && HREADY_I)
        begin
          n.bus      = tbgi_pkg::BUS_DATA;
          n.bus_we   = HWRITE_I;
          n.bus_addr = HADDR_I[7:0];
          n.hready   = 1'h0;
        end
      end
      tbgi_pkg::BUS_DATA:
      begin
        n.bus    = tbgi_pkg::BUS_IDLE;
        n.hready = 1'h1;
        if (!r.bus_we)
        begin
          n.hrdata = rd;
        end
        else
        begin
          case (r.bus_addr)
            tbgi_pkg::ADDR_PSC: n.psc_src = HWDATA_I[1:0];
            tbgi_pkg::ADDR_TIME_BASE1_CONTROL:
            begin
              n.tb_on  = HWDATA_I[tbgi_pkg::TIME_BASE1_CONTROL_ON_BIT];
              n.tb_sel = HWDATA_I[2:0];
            end
            tbgi_pkg::ADDR_CORE_EN:
            begin
              n.glb_en = HWDATA_I[tbgi_pkg::CORE_GLB_BIT];
              n.spi_en = HWDATA_I[tbgi_pkg::CORE_SPI_LSB +: tbgi_pkg::NUM_SPI];
              n.tb_en  = HWDATA_I[tbgi_pkg::CORE_TB_BIT];
              n.grp_en = HWDATA_I[tbgi_pkg::CORE_GRP_LSB +: tbgi_pkg::NUM_GRP];
            end
            tbgi_pkg::ADDR_CORE_FLG:
            begin
              n.spi_f = HWDATA_I[tbgi_pkg::FLG_SPI_LSB +: tbgi_pkg::NUM_SPI];
              n.tb_f  = HWDATA_I[tbgi_pkg::FLG_TB_BIT];
              n.grp_f = HWDATA_I[tbgi_pkg::FLG_GRP_LSB +: tbgi_pkg::NUM_GRP];
            end
            tbgi_pkg::ADDR_SRC_EN:  n.src_en = HWDATA_I[tbgi_pkg::NUM_SRC-1:0];
            tbgi_pkg::ADDR_SRC_FLG: n.src_f  = HWDATA_I[tbgi_pkg::NUM_SRC-1:0];
            default:                n.src_f  = n.src_f;
          endcase
        end
      end
      default:
      begin
        n.bus    = tbgi_pkg::BUS_IDLE;
        n.hready = 1'h1;
      end
    endcase

    // Service: the core takes the offered vector, which drops global enable and that flag.
    ack = IRQ_ACK_I && r.irq_req;
    if (ack)
    begin
      n.glb_en = 1'h0;
      if (r.irq_vec < tbgi_pkg::VEC_GRP0)
      begin
        n.spi_f[r.irq_vec[0]] = 1'h0;
      end
      else if (r.irq_vec == tbgi_pkg::VEC_TB1)
      begin
        n.tb_f = 1'h0;
      end
      else
      begin
        n.grp_f[2'(r.irq_vec - tbgi_pkg::VEC_GRP0)] = 1'h0;
      end
    end

    // Hardware sets come last so an event in the clearing cycle is never lost.
    n.spi_f = n.spi_f | SPI_BYTE_DONE_I | SPI_ABORT_I;
    n.tb_f  = n.tb_f | tb_expire;
    n.grp_f = n.grp_f | grp_set;
    n.src_f = n.src_f | src_set;

    // Pending calls, with the request withdrawn in the cycle it is taken.
    pend[tbgi_pkg::VEC_SPI0 +: tbgi_pkg::NUM_SPI] = r.spi_f & r.spi_en;
    pend[tbgi_pkg::VEC_GRP0 +: tbgi_pkg::NUM_GRP] = r.grp_f & r.grp_en & grp_ready;
    pend[tbgi_pkg::VEC_TB1] = r.tb_f & r.tb_en;
    n.irq_req = r.glb_en && !STACK_FULL_I && (|pend) && !ack;
    n.irq_vec = prio(pend);

    // Wake-up on any rising flag, enabled or not.
    n.wake = |(all_flags(n) & ~all_flags(r));
  end

  // State register.
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      r <= tbgi_pkg::STATE_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------

  // Every output but HRESP_O is a state flop; HRESP_O is tied low, so the slave never signals an error.
  assign HREADYOUT_O = r.hready;
  assign HRDATA_O    = r.hrdata;
  assign HRESP_O     = 1'h0;
  assign IRQ_REQ_O   = r.irq_req;
  assign IRQ_VEC_O   = r.irq_vec;
  assign WAKE_O      = r.wake;

  // Plain flag vector, so the wake check can look one cycle back at a signal.
  assign flg_now     = all_flags(r);

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  // A disabled time base holds its counter at zero and never raises its own flag.
  property p_tb_off;
    !r.tb_on && !(r.bus == tbgi_pkg::BUS_DATA && r.bus_we)
      |=> r.tb_cnt == '0 && !$rose(r.tb_f);
  endproperty
  a_tb_off: assert property (p_tb_off)
    else $error("time base expired while disabled");

  // Expiry only when the selected low counter bits are all ones, then they wrap.
  property p_tb_period;
    tb_expire |=> (r.tb_cnt & tb_mask($past(r.tb_sel))) == '0;
  endproperty
  a_tb_period: assert property (p_tb_period)
    else $error("time base period boundary wrong");

  // Reserved control bits read as zero.
  property p_time_base1_control_rsvd;
    r.bus == tbgi_pkg::BUS_DATA && !r.bus_we && r.bus_addr == tbgi_pkg::ADDR_TIME_BASE1_CONTROL
      |=> HRDATA_O[6:3] == 4'h0 && HREADYOUT_O;
  endproperty
  a_time_base1_control_rsvd: assert property (p_time_base1_control_rsvd)
    else $error("reserved time base bits read non-zero");

  // A serial peripheral 0 event always leaves its flag set.
  property p_spi_set;
    SPI_BYTE_DONE_I[0] || SPI_ABORT_I[0] |=> r.spi_f[0];
  endproperty
  a_spi_set: assert property (p_spi_set)
    else $error("serial peripheral flag not set");

  // A request is offered only with global enable and a free stack one cycle before.
  property p_req_cause;
    r.irq_req |-> $past(r.glb_en) && !$past(STACK_FULL_I);
  endproperty
  a_req_cause: assert property (p_req_cause)
    else $error("request offered without enable or stack room");

  // Serving serial peripheral 0 clears its flag and the global enable.
  property p_spi_serve;
    ack && r.irq_vec == tbgi_pkg::VEC_SPI0 && !SPI_BYTE_DONE_I[0] && !SPI_ABORT_I[0]
      && r.bus != tbgi_pkg::BUS_DATA |=> !r.spi_f[0] && !r.glb_en && !r.irq_req;
  endproperty
  a_spi_serve: assert property (p_spi_serve)
    else $error("serial peripheral service did not clear flag and enable");

  // Serving a group never clears a source flag.
  property p_grp_keep;
    ack && r.irq_vec >= tbgi_pkg::VEC_GRP0 && r.irq_vec < tbgi_pkg::VEC_TB1
      && r.bus != tbgi_pkg::BUS_DATA |=> ($past(r.src_f) & ~r.src_f) == '0 && !r.glb_en;
  endproperty
  a_grp_keep: assert property (p_grp_keep)
    else $error("group service cleared a source flag");

  // A member event of group 0 sets the group flag.
  property p_grp_set;
    (src_set & tbgi_pkg::GRP_MASK[0]) != '0 |=> r.grp_f[0];
  endproperty
  a_grp_set: assert property (p_grp_set)
    else $error("group flag not set by member");

  // A rising flag raises the wake output in the same cycle.
  property p_wake;
    (flg_now & ~$past(flg_now)) != '0 |-> WAKE_O;
  endproperty
  a_wake: assert property (p_wake)
    else $error("rising flag without wake");

  // Serial peripheral 0, pending and enabled, is never passed over for another vector.
  property p_prio;
    r.irq_req && r.irq_vec != tbgi_pkg::VEC_SPI0 |-> !($past(r.spi_f[0]) && $past(r.spi_en[0]));
  endproperty
  a_prio: assert property (p_prio)
    else $error("lower vector was pending but not chosen");

endmodule

// ===== src/tbgi_pkg.sv
// Overview of operation
// - Time base 1 counts only while its enable bit, the control register's top bit, is one.
// - Period select n gives a time base 1 period of 2^(8+n) prescaler ticks.
// - Bits 6 to 3 of the time base 1 control register read as zero.
// - Each serial peripheral flag sets on byte done or on an incomplete transfer.
// - Serial peripheral call needs global enable, own enable and a stack not full.
// - Serving a serial peripheral call clears global enable and that instance's flag.
// - Four grouped interrupts collect timer, two-wire, low-voltage, EEPROM, comparator, converter requests.
// - A group flag sets when any member source sets; enabled group calls if stack free.
// - Serving a group clears only group flag and global enable; software clears sources.
// - Each timer has two flags and enables, for comparator A and P matches.
// - Timer match calls through its group with global, timer and group enables set.
// - Two-wire flag sets on address match, byte done or bus time-out.
// - Two-wire request calls through its group with global, group and own enables set.
// - Low-voltage flag sets on low supply; calls with global, own, group enables.
// - EEPROM flag sets at write end; calls with global, own and group enables.
// - Comparator flag sets on output change; calls with global, own, group enables.
// - Converter flag sets at conversion end; calls with global, own, group enables.
// - Prescaler source: 00 system clock, 01 system clock over four, 1x sub clock.
// - Each time base expiry sets that time base's request flag.
// - Any request flag rising wakes the device, whatever the enables.
package tbgi_pkg;

  // -------------------------------------------------------------------------
  // Sizes
  // -------------------------------------------------------------------------
  localparam int NUM_SPI  = 2;
  localparam int NUM_TM   = 4;
  localparam int NUM_GRP  = 4;
  localparam int NUM_CMP  = 2;
  localparam int NUM_SRC  = 14;
  localparam int NUM_FLG  = 21;
  localparam int TB_CNT_W = 15;
  localparam int TB_BASE  = 8;

  // -------------------------------------------------------------------------
  // Register map, byte addresses, and field positions
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADDR_PSC      = 8'h00;
  localparam logic [7:0] ADDR_TIME_BASE1_CONTROL     = 8'h04;
  localparam logic [7:0] ADDR_CORE_EN  = 8'h08;
  localparam logic [7:0] ADDR_CORE_FLG = 8'h0C;
  localparam logic [7:0] ADDR_SRC_EN   = 8'h10;
  localparam logic [7:0] ADDR_SRC_FLG  = 8'h14;
  localparam int TIME_BASE1_CONTROL_ON_BIT  = 7;
  localparam int CORE_GLB_BIT = 0;
  localparam int CORE_SPI_LSB = 1;
  localparam int CORE_TB_BIT  = 3;
  localparam int CORE_GRP_LSB = 4;
  localparam int FLG_SPI_LSB  = 0;
  localparam int FLG_TB_BIT   = 2;
  localparam int FLG_GRP_LSB  = 3;
  localparam logic [7:0] TIME_BASE1_CONTROL_RESET = 8'h00;

  // -------------------------------------------------------------------------
  // Source bits inside the grouped flag and enable registers
  // -------------------------------------------------------------------------
  localparam int SRC_TWI = 8;
  localparam int SRC_LVD = 9;
  localparam int SRC_EEP = 10;
  localparam int SRC_CMP = 11;
  localparam int SRC_ADC = 13;
  localparam logic [NUM_GRP-1:0][NUM_SRC-1:0] GRP_MASK =
    {14'h3800, 14'h0700, 14'h00F0, 14'h000F};

  // -------------------------------------------------------------------------
  // Prescaler sources and vectors, lowest index served first
  // -------------------------------------------------------------------------
  localparam logic [1:0] PSC_SYS  = 2'h0;
  localparam logic [1:0] PSC_DIV4 = 2'h1;
  localparam logic [1:0] DIV4_END = 2'h3;
  localparam logic [2:0] VEC_SPI0 = 3'h0;
  localparam logic [2:0] VEC_GRP0 = 3'h2;
  localparam logic [2:0] VEC_TB1  = 3'h6;
  localparam int NUM_VEC = 7;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_DATA = 2'h1
  } tbgi_bus_t;

  typedef struct packed {
    tbgi_bus_t            bus;
    logic                 bus_we;
    logic [7:0]           bus_addr;
    logic                 hready;
    logic [31:0]          hrdata;
    logic [1:0]           psc_src;
    logic                 tb_on;
    logic [2:0]           tb_sel;
    logic [1:0]           div_cnt;
    logic [TB_CNT_W-1:0]  tb_cnt;
    logic                 glb_en;
    logic [NUM_SPI-1:0]   spi_en;
    logic                 tb_en;
    logic [NUM_GRP-1:0]   grp_en;
    logic [NUM_SPI-1:0]   spi_f;
    logic                 tb_f;
    logic [NUM_GRP-1:0]   grp_f;
    logic [NUM_SRC-1:0]   src_en;
    logic [NUM_SRC-1:0]   src_f;
    logic [2:0]           sub_s;
    logic [2:0]           lv_s;
    logic [NUM_CMP-1:0]   cmp_s1;
    logic [NUM_CMP-1:0]   cmp_s2;
    logic [NUM_CMP-1:0]   cmp_s3;
    logic                 irq_req;
    logic [2:0]           irq_vec;
    logic                 wake;
  } tbgi_state_t;

  localparam tbgi_state_t STATE_RESET = '{bus: BUS_IDLE, hready: 1'h1, default: '0};

endpackage
